// *** cpio_board_model.sv ***
`timescale 1ns/1ns
`default_nettype none
//==============================================================
// Board side of one port: resolves each pin from all its drivers
module cpio_board_model (
  // Clock
  input wire logic       sys_clk,
  // Device pin controls
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] weakPull,
  // Board drive
  input wire logic [7:0] extVal,
  input wire logic [7:0] extEn,
  // Resolved level
  output logic [7:0]     level
);
  logic [7:0] drift = 8'h55;

  // Floating pins wander each cycle so a stale level is never read back
  always_ff @(posedge sys_clk) drift <= ~drift;

  // Device drive wins, then the board, then the weak pullup
  assign level = (pinOe & pinOut) | (~pinOe & extEn & extVal)
               | (~pinOe & ~extEn & (weakPull | drift & ~weakPull));
endmodule : cpio_board_model
`default_nettype wire

// *** cpio_crossbar_port_io.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cpio_defines.svh"

//==============================================================
// Two-flop pin synchroniser; only the second stage is read
module cpio_pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // Pin in, synchronised level out
  input  wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0]      pinSync
);
  logic [WIDTH-1:0] pinMeta;

  // Resets high, the idle level of a pulled-up pin, so no false edge follows
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta <= '1;
      pinSync <= '1;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end
endmodule : cpio_pin_sync

module cpio_crossbar_port_io #(
  parameter bit LARGE_PACKAGE = 1'b0
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  // Special function register bus
  input  wire logic [7:0]            sfrAddr,
  input  wire logic                  sfrWrite,
  input  wire logic [7:0]            sfrWdata,
  input  wire logic                  sfrRead,
  input  wire logic                  sfrRmw,
  output logic [7:0]                 sfrRdata,
  // Settings from other blocks
  input  wire logic [1:0]            clock_out_divider,
  input  wire logic [1:0]            slave_select_mode,
  input  wire logic                  match_irq_enable,
  // Peripheral side
  input  wire cpio_pkg::cpio_sigvec_t periphOut,
  input  wire cpio_pkg::cpio_sigvec_t periphOe,
  output cpio_pkg::cpio_sigvec_t     periphIn,
  // Port 0 pins
  input  wire logic [7:0]            port0PinIn,
  output logic [7:0]                 port0PinOut,
  output logic [7:0]                 port0PinOe,
  output logic [7:0]                 port0Pullup,
  // Port 1 pins
  input  wire logic [7:0]            port1PinIn,
  output logic [7:0]                 port1PinOut,
  output logic [7:0]                 port1PinOe,
  output logic [7:0]                 port1Pullup,
  // Match event
  output logic                       matchEvent,
  output logic                       matchIrqReq,
  output logic                       oscWake
);

  //==============================================================
  // Registers
  cpio_pkg::cpio_byte_t port0_data_latch;
  cpio_pkg::cpio_byte_t port1_data_latch;
  cpio_pkg::cpio_byte_t port0_output_mode;
  cpio_pkg::cpio_byte_t port0_skip_select;
  cpio_pkg::cpio_byte_t crossbar_route_a;
  cpio_pkg::cpio_byte_t crossbar_route_b;
  cpio_pkg::cpio_byte_t port0_input_mode;
  cpio_pkg::cpio_byte_t port0_match_value;
  cpio_pkg::cpio_byte_t port0_match_mask;

  //==============================================================
  // Address decode
  wire hitP0      = sfrAddr == `CPIO_ADDR_P0_LATCH;
  wire hitP1      = sfrAddr == `CPIO_ADDR_P1_LATCH;
  wire hitOutMode = sfrAddr == `CPIO_ADDR_P0_OUTMODE;
  wire hitSkip    = sfrAddr == `CPIO_ADDR_P0_SKIP;
  wire hitRouteA  = sfrAddr == `CPIO_ADDR_ROUTE_A;
  wire hitRouteB  = sfrAddr == `CPIO_ADDR_ROUTE_B;
  wire hitInMode  = sfrAddr == `CPIO_ADDR_P0_INMODE;
  wire hitMatVal  = sfrAddr == `CPIO_ADDR_P0_MATVAL;
  wire hitMatMask = sfrAddr == `CPIO_ADDR_P0_MATMASK;

  // Register writes; port latches only hold the value, pins follow later
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      port0_data_latch  <= `CPIO_RST_LATCH;
      port1_data_latch  <= `CPIO_RST_LATCH;
      port0_output_mode <= `CPIO_RST_OUTMODE;
      port0_skip_select <= `CPIO_RST_SKIP;
      crossbar_route_a  <= `CPIO_RST_ROUTE;
      crossbar_route_b  <= `CPIO_RST_ROUTE;
      port0_input_mode  <= `CPIO_RST_INMODE;  // [R19]
      port0_match_value <= `CPIO_RST_MATVAL;
      port0_match_mask  <= `CPIO_RST_MATMASK;
    end else if (sfrWrite) begin
      if (hitP0) port0_data_latch <= sfrWdata;  // [R11]
      if (hitP1) port1_data_latch <= sfrWdata;  // [R11]
      if (hitOutMode) port0_output_mode <= sfrWdata;
      if (hitSkip) port0_skip_select <= sfrWdata;
      if (hitRouteA) crossbar_route_a <= sfrWdata;
      if (hitRouteB) crossbar_route_b <= sfrWdata;
      if (hitInMode) port0_input_mode <= sfrWdata;
      if (hitMatVal) port0_match_value <= sfrWdata;
      if (hitMatMask) port0_match_mask <= sfrWdata;
    end
  end

  //==============================================================
  // Pin synchronisers; first stage feeds only the second
  logic [7:0] p0Sync;
  logic [7:0] p1Sync;

  cpio_pin_sync #(
    .WIDTH(8)
  ) u_p0Sync (
    .sys_clk(sys_clk),
    .rst_b  (rst_b),
    .pinIn  (port0PinIn),
    .pinSync(p0Sync)
  );

  cpio_pin_sync #(
    .WIDTH(8)
  ) u_p1Sync (
    .sys_clk(sys_clk),
    .rst_b  (rst_b),
    .pinIn  (port1PinIn),
    .pinSync(p1Sync)
  );

  //==============================================================
  // Read path
  // Analog pins read 0 on ordinary reads; latch returned on RMW reads
  wire [7:0] p0Live = p0Sync & port0_input_mode;  // [R12] [R18]
  wire [7:0] p0Read = sfrRmw ? port0_data_latch : p0Live;  // [R13]
  wire [7:0] p1Read = sfrRmw ? port1_data_latch : p1Sync;  // [R12] [R13]
  wire [7:0] next_rdata =
    hitP0      ? p0Read :
    hitP1      ? p1Read :
    hitOutMode ? port0_output_mode :
    hitSkip    ? port0_skip_select :
    hitRouteA  ? crossbar_route_a :
    hitRouteB  ? crossbar_route_b :
    hitInMode  ? port0_input_mode :
    hitMatVal  ? port0_match_value :
    hitMatMask ? port0_match_mask : 8'h00;  // Unmapped reads 0

  // Read data is held until the next read
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfrRdata <= 8'h00;
    end else if (sfrRead) begin
      sfrRdata <= next_rdata;
    end
  end

  //==============================================================
  // Control fields
  wire       xbarOn     = crossbar_route_b[`CPIO_B_XBAR_EN];  // [R7]
  wire       pullupOff  = crossbar_route_b[`CPIO_B_PULLUP_DIS];
  wire [2:0] captField  = crossbar_route_b[`CPIO_B_CAPT_HI:`CPIO_B_CAPT_LO];
  // Reserved code 111 treated as no modules routed
  wire [2:0] captCount  = (captField == `CPIO_CAPT_RSVD) ? 3'h0 : captField;  // [R10]
  wire       fourWire   = slave_select_mode != 2'h0;  // [R4]
  wire       uartOn     = xbarOn & crossbar_route_a[`CPIO_A_ASYNC];  // [R5]

  // Per-signal enables in priority order
  cpio_pkg::cpio_sigvec_t sigEn;
  always_comb begin
    sigEn = '0;
    sigEn[`CPIO_SIG_SCK]  = crossbar_route_a[`CPIO_A_SERIAL];  // [R4]
    sigEn[`CPIO_SIG_MISO] = crossbar_route_a[`CPIO_A_SERIAL];
    sigEn[`CPIO_SIG_MOSI] = crossbar_route_a[`CPIO_A_SERIAL];
    sigEn[`CPIO_SIG_NSS]  = crossbar_route_a[`CPIO_A_SERIAL] & fourWire;
    sigEn[`CPIO_SIG_SDA]  = crossbar_route_a[`CPIO_A_TWOWIRE];  // [R3] [R26]
    sigEn[`CPIO_SIG_SCL]  = crossbar_route_a[`CPIO_A_TWOWIRE];
    sigEn[`CPIO_SIG_CP0]  = crossbar_route_a[`CPIO_A_CMP0_SYNC];  // [R1]
    sigEn[`CPIO_SIG_CP0A] = crossbar_route_a[`CPIO_A_CMP0_ASYNC];
    sigEn[`CPIO_SIG_CP1]  = crossbar_route_a[`CPIO_A_CMP1_SYNC];
    sigEn[`CPIO_SIG_CP1A] = crossbar_route_a[`CPIO_A_CMP1_ASYNC];
    sigEn[`CPIO_SIG_CLK]  = crossbar_route_a[`CPIO_A_CLOCK_OUT];  // [R2]
    for (int m = 0; m < 6; m++) begin
      sigEn[`CPIO_SIG_CAPTURE_MODULE_OUT_FIRST + m] = m < int'(captCount);  // [R10]
    end
    sigEn[`CPIO_SIG_ECI]  = crossbar_route_b[`CPIO_B_COUNTER];  // [R9]
    sigEn[`CPIO_SIG_T0]   = crossbar_route_b[`CPIO_B_TIMER0];  // [R8]
    sigEn[`CPIO_SIG_T1]   = crossbar_route_b[`CPIO_B_TIMER1];  // [R8]
    if (!xbarOn) sigEn = '0;  // [R7] [R24]
  end

  //==============================================================
  // Clock output divider
  // Counter bit n toggles every 2^n cycles, so each tap is one octave below its nominal division: sys_clk/2, /4, /8 or /16
  logic [3:0] clkDiv;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clkDiv <= 4'h0;
    end else begin
      clkDiv <= clkDiv + 4'h1;
    end
  end
  wire clockOutBit = clkDiv[clock_out_divider];  // [R2]

  // Signal values with the clock output inserted locally
  cpio_pkg::cpio_sigvec_t sigOut;
  cpio_pkg::cpio_sigvec_t sigDrv;
  always_comb begin
    sigOut = periphOut;
    sigDrv = periphOe & `CPIO_SIG_DRIVES;
    sigOut[`CPIO_SIG_CLK] = clockOutBit;
    sigDrv[`CPIO_SIG_CLK] = 1'b1;
  end

  //==============================================================
  // Priority decoder
  // Full combinational search each cycle; 22 signals over 8 pins is cheap
  localparam int TX_PIN = LARGE_PACKAGE ? `CPIO_TX_PIN_LARGE : `CPIO_TX_PIN_SMALL;
  localparam int RX_PIN = LARGE_PACKAGE ? `CPIO_RX_PIN_LARGE : `CPIO_RX_PIN_SMALL;

  cpio_pkg::cpio_sel_t pinSel [8];
  logic [7:0]          pinAssigned;
  logic [7:0]          taken;
  logic                placed;
  always_comb begin
    taken       = port0_skip_select;  // [R22]
    pinAssigned = 8'h00;
    placed      = 1'b0;
    for (int p = 0; p < 8; p++) begin
      pinSel[p] = 5'h00;
    end
    // Async serial sits on fixed pins ahead of everything else
    if (uartOn) begin  // [R5] [R26]
      taken[TX_PIN]       = 1'b1;
      taken[RX_PIN]       = 1'b1;
      pinAssigned[TX_PIN] = 1'b1;
      pinAssigned[RX_PIN] = 1'b1;
      pinSel[TX_PIN]      = 5'(`CPIO_SIG_TX);
      pinSel[RX_PIN]      = 5'(`CPIO_SIG_RX);
    end
    // Remaining signals take the lowest free pin in table order
    for (int s = `CPIO_SIG_SCK; s < `CPIO_NUM_SIG; s++) begin  // [R27]
      placed = 1'b0;
      for (int p = 0; p < 8; p++) begin
        if (sigEn[s] && !taken[p] && !placed) begin  // [R23]
          taken[p]       = 1'b1;
          pinAssigned[p] = 1'b1;
          pinSel[p]      = 5'(s);
          placed         = 1'b1;
        end
      end
    end
  end

  //==============================================================
  // Pin drivers for port 0
  logic [7:0] next_p0Out;
  logic [7:0] next_p0Oe;
  logic [7:0] next_p0Pull;
  logic [7:0] twoWirePin;
  logic [7:0] wantDrive;
  logic [7:0] openDrain;
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      twoWirePin[p] = pinAssigned[p] &&
                      (pinSel[p] == 5'(`CPIO_SIG_SDA) || pinSel[p] == 5'(`CPIO_SIG_SCL));
      if (pinAssigned[p]) begin
        next_p0Out[p] = sigOut[pinSel[p]];
        wantDrive[p]  = sigDrv[pinSel[p]];
      end else begin
        next_p0Out[p] = port0_data_latch[p];
        wantDrive[p]  = 1'b1;
      end
    end
    openDrain = ~port0_output_mode | twoWirePin;  // [R20] [R21]
    // Open-drain lets a 1 float; a 0 pulls low
    for (int p = 0; p < 8; p++) begin
      next_p0Oe[p] = wantDrive[p] & (openDrain[p] ? ~next_p0Out[p] : 1'b1);  // [R17]
    end
    next_p0Oe = next_p0Oe & port0_input_mode;  // [R19]
    if (!xbarOn) next_p0Oe = 8'h00;  // [R24]
    // Weak pullup only on open-drain digital pins not pulling low
    next_p0Pull = {8{!pullupOff}} & openDrain & port0_input_mode
                  & ~(next_p0Oe & ~next_p0Out);  // [R6] [R25]
  end

  // Port 1 is plain open-drain general purpose I/O
  wire [7:0] next_p1Oe   = xbarOn ? ~port1_data_latch : 8'h00;  // [R17] [R24]
  wire [7:0] next_p1Pull = {8{!pullupOff}} & ~next_p1Oe;  // [R6] [R25]

  //==============================================================
  // Inputs returned to peripherals; unrouted inputs idle high
  cpio_pkg::cpio_sigvec_t next_periphIn;
  always_comb begin
    next_periphIn = '1;
    for (int p = 0; p < 8; p++) begin
      if (pinAssigned[p]) begin
        next_periphIn[pinSel[p]] = p0Sync[p];
      end
    end
  end

  //==============================================================
  // Match comparator; masked-out pins never take part
  wire mismatch = |((p0Sync ^ port0_match_value) & port0_match_mask);  // [R14] [R16]

  //==============================================================
  // Output registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      port0PinOut <= 8'hff;
      port0PinOe  <= 8'h00;
      port0Pullup <= 8'h00;
      port1PinOut <= 8'hff;
      port1PinOe  <= 8'h00;
      port1Pullup <= 8'h00;
      periphIn    <= '1;
      matchEvent  <= 1'b0;
      matchIrqReq <= 1'b0;
      oscWake     <= 1'b0;
    end else begin
      port0PinOut <= next_p0Out;
      port0PinOe  <= next_p0Oe;
      port0Pullup <= next_p0Pull;
      port1PinOut <= port1_data_latch;
      port1PinOe  <= next_p1Oe;
      port1Pullup <= next_p1Pull;
      periphIn    <= next_periphIn;
      matchEvent  <= mismatch;  // [R14]
      matchIrqReq <= mismatch & match_irq_enable;  // [R15]
      oscWake     <= mismatch;  // [R15]
    end
  end

endmodule : cpio_crossbar_port_io
`default_nettype wire

// *** cpio_crossbar_port_io_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
//==============================================================
// Register-sequence bench
module cpio_crossbar_port_io_tb_top;
  logic sys_clk, rst_b, sfrWrite, sfrRead, sfrRmw, irqEn;
  logic [1:0] ssMode, clkSel;
  logic matchEvent, matchIrqReq, oscWake;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, v, ext0, ext1, extEn0, extEn1;
  logic [7:0] port0PinIn, port0PinOut, port0PinOe, port0Pullup;
  logic [7:0] port1PinIn, port1PinOut, port1PinOe, port1Pullup;
  cpio_pkg::cpio_sigvec_t periphOut, periphOe, periphIn;
  int n_errors, comparisons;
  logic [7:0] addrs [9] = '{8'h80, 8'h90, 8'ha4, 8'hd4, 8'he1, 8'he2, 8'hf1, 8'hf3, 8'hf4};
  logic [7:0] rsts [9] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};

  cpio_crossbar_port_io uut (.sys_clk(sys_clk), .rst_b(rst_b), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrRead(sfrRead), .sfrRmw(sfrRmw),
    .sfrRdata(sfrRdata), .clock_out_divider(clkSel), .slave_select_mode(ssMode),
    .match_irq_enable(irqEn), .periphOut(periphOut), .periphOe(periphOe),
    .periphIn(periphIn), .port0PinIn(port0PinIn), .port0PinOut(port0PinOut),
    .port0PinOe(port0PinOe), .port0Pullup(port0Pullup), .port1PinIn(port1PinIn),
    .port1PinOut(port1PinOut), .port1PinOe(port1PinOe), .port1Pullup(port1Pullup),
    .matchEvent(matchEvent), .matchIrqReq(matchIrqReq), .oscWake(oscWake));
  cpio_board_model b0 (.sys_clk(sys_clk), .pinOut(port0PinOut), .pinOe(port0PinOe),
    .weakPull(port0Pullup), .extVal(ext0), .extEn(extEn0), .level(port0PinIn));
  cpio_board_model b1 (.sys_clk(sys_clk), .pinOut(port1PinOut), .pinOe(port1PinOe),
    .weakPull(port1Pullup), .extVal(ext1), .extEn(extEn1), .level(port1PinIn));

  //==============================================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Write, then let pins and synchronisers settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfrAddr <= a;
    sfrWdata <= d;
    sfrWrite <= 1'b1;
    @(posedge sys_clk);
    sfrWrite <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] d);
    @(posedge sys_clk);
    sfrAddr <= a;
    sfrRead <= 1'b1;
    sfrRmw <= m;
    @(posedge sys_clk);
    sfrRead <= 1'b0;
    sfrRmw <= 1'b0;
    #1 d = sfrRdata;
  endtask : rd

  task automatic conclude();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  //==============================================================
  // Clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    conclude();
  end

  //==============================================================
  // Main sequence
  initial begin
    {rst_b, sfrWrite, sfrRead, sfrRmw, irqEn, sfrAddr, sfrWdata} = '0;
    {ext0, ext1, extEn0, extEn1, periphOut, periphOe, ssMode, clkSel} = '0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      rd(addrs[i], 1'b0, v);
      check(v, rsts[i]);
    end
    rd(8'h81, 1'b0, v);
    check(v, 8'h00);
    check(port1Pullup, 8'hff);
    // Match on pin 0 held low by the board, crossbar still off
    extEn0 <= 8'h01;
    wr(8'hf4, 8'h01);
    check({7'h00, matchEvent}, 8'h01);
    check({6'h00, matchIrqReq, oscWake}, 8'h01);
    @(posedge sys_clk);
    irqEn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 check({6'h00, matchIrqReq, oscWake}, 8'h03);
    wr(8'hf3, 8'hfe);
    check({7'h00, matchEvent}, 8'h00);
    wr(8'hf3, 8'hff);
    wr(8'hf4, 8'h00);
    check({7'h00, matchEvent}, 8'h00);
    extEn0 <= 8'h00;
    // Latch and drivers, before and after the crossbar is enabled
    wr(8'h80, 8'h00);
    check(port0PinOe, 8'h00);
    rd(8'h80, 1'b0, v);
    check(v, 8'hff);
    wr(8'he2, 8'h40);
    check(port0PinOe, 8'hff);
    check(port0PinOut & port0PinOe, 8'h00);
    check(port0Pullup, 8'h00);
    rd(8'h80, 1'b0, v);
    check(v, 8'h00);
    wr(8'h80, 8'hff);
    check(port0PinOe, 8'h00);
    check(port0Pullup, 8'hff);
    wr(8'ha4, 8'hff);
    check(port0PinOe & port0PinOut, 8'hff);
    check(port0Pullup, 8'h00);
    wr(8'hf1, 8'h0f);
    check(port0PinOe, 8'h0f);
    rd(8'h80, 1'b0, v);
    check(v, 8'h0f);
    rd(8'h80, 1'b1, v);
    check(v, 8'hff);
    wr(8'hf1, 8'hff);
    // Port 1 latch against pins the board pulls low
    wr(8'h90, 8'h5a);
    check(port1PinOe, 8'ha5);
    check(port1Pullup, 8'h5a);
    extEn1 <= 8'hff;
    repeat (3) @(posedge sys_clk);
    rd(8'h90, 1'b0, v);
    check(v, 8'h00);
    rd(8'h90, 1'b1, v);
    check(v, 8'h5a);
    extEn1 <= 8'h00;
    // Routing: async serial on fixed pins 4/5, two-wire on the lowest free pins
    @(posedge sys_clk);
    periphOe <= 22'h0000c1;
    periphOut <= 22'h000040;
    extEn0 <= 8'h20;
    wr(8'he1, 8'h05);
    check(port0PinOe, 8'hde);
    check(port0PinOut & port0PinOe, 8'hcc);
    check({7'h00, periphIn[1]}, 8'h00);
    wr(8'hd4, 8'h01);
    check(port0PinOe, 8'hdd);
    check(port0PinOut & port0PinOe, 8'hc9);
    @(posedge sys_clk);
    periphOe <= 22'h0021c1;
    wr(8'he1, 8'h15);
    check(port0PinOut & port0PinOe, 8'hc1);
    wr(8'he2, 8'h41);
    check(port0PinOut & port0PinOe, 8'h81);
    wr(8'he2, 8'h47);
    check(port0PinOut & port0PinOe, 8'hc1);
    // Serial lines by select mode, counter and timer inputs, clock output taps
    @(posedge sys_clk);
    ssMode <= 2'h1;
    extEn0 <= 8'h30;
    wr(8'he1, 8'h02);
    check(port0PinOe, 8'he1);
    @(posedge sys_clk);
    ssMode <= 2'h0;
    repeat (2) @(posedge sys_clk);
    #1 check(port0PinOe, 8'hf1);
    wr(8'he2, 8'h58);
    check(port0PinOe, 8'hc1);
    check({5'h00, periphIn[21:19]}, 8'h04);
    wr(8'he1, 8'h08);
    v = port0PinOut;
    @(posedge sys_clk);
    #1 check(port0PinOut & 8'h02, ~v & 8'h02);
    @(posedge sys_clk);
    clkSel <= 2'h1;
    repeat (2) @(posedge sys_clk);
    #1 v = port0PinOut;
    repeat (2) @(posedge sys_clk);
    #1 check(port0PinOut & 8'h02, ~v & 8'h02);
    wr(8'he2, 8'hc0);
    check(port1Pullup, 8'h00);
    wr(8'he2, 8'h00);
    check(port0PinOe | port1PinOe, 8'h00);
    conclude();
  end
endmodule : cpio_crossbar_port_io_tb_top
`default_nettype wire

// *** cpio_defines.svh ***
//==============================================================
// Operation
// [R1] Route bits 7..4 enable comparator 1 async, 1 sync, 0 async, 0 sync outputs.
// [R2] Route bit 3 sends the system clock, divided by 1/2/4/8, to a pin. The code divides by 2/4/8/16.
// [R3] Route bit 2 places two-wire data and clock on pins; clear places neither.
// [R4] Route bit 1 places serial peripheral lines, three or four by select mode.
// [R5] Route bit 0 places async transmit/receive on fixed pins, not by priority.
// [R6] Pullup-disable bit 7 at 0 enables weak pullups except analog pins. The code also keeps them off on port 0 push-pull pins.
// [R7] Bit 6 enables the crossbar; assignments apply only while it is set.
// [R8] Bits 5 and 4 route timer 1 and timer 0 inputs when set.
// [R9] Bit 3 routes the counter external input when set.
// [R10] Capture field 000 routes none, 001..110 route first N modules, 111 reserved.
// [R11] Writes to a port data register are stored in the port latch.
// [R12] Ordinary port reads return live pin levels whatever the crossbar does.
// [R13] Read-modify-write reads return the latch, not the pins.
// [R14] Match event when masked pins differ from masked match value.
// [R15] Match event requests interrupt when enabled and wakes the oscillator.
// [R16] Mask bit 0 excludes the pin from matching; 1 compares it.
// [R17] Open-drain pin with latch 1 floats; latch 0 drives low.
// [R18] Reads of analog-mode pins return 0; digital pins return the level.
// [R19] Input-mode bit 0 makes pin analog, no pullup, driver or receiver. The code still feeds such pins to match and peripheral inputs.
// [R20] Output-mode 0 open-drain, 1 push-pull, ignored for analog pins.
// [R21] Pins carrying two-wire data or clock are always open-drain.
// [R22] Skip bit 1 makes crossbar pass over the pin as if assigned.
// [R23] Enabled peripherals take lowest free unskipped pin in priority order.
// [R24] Crossbar disabled keeps all pins inputs with output drivers off.
// [R25] Pullup off on pins driving 0 and analog pins; push-pull unaffected. The code also turns it off on port 0 push-pull pins.
// [R26] Two-wire enable takes both pins; async serial enable takes both pins.
// [R27] Priority table: async serial, SPI, two-wire, comparators, clock, capture, counter, timers.
`ifndef CPIO_DEFINES_SVH
`define CPIO_DEFINES_SVH

//==============================================================
// Register addresses
`define CPIO_ADDR_P0_LATCH   8'h80
`define CPIO_ADDR_P1_LATCH   8'h90
`define CPIO_ADDR_P0_OUTMODE 8'ha4
`define CPIO_ADDR_P0_SKIP    8'hd4
`define CPIO_ADDR_ROUTE_A    8'he1
`define CPIO_ADDR_ROUTE_B    8'he2
`define CPIO_ADDR_P0_INMODE  8'hf1
`define CPIO_ADDR_P0_MATVAL  8'hf3
`define CPIO_ADDR_P0_MATMASK 8'hf4

//==============================================================
// Reset values
`define CPIO_RST_LATCH   8'hff
`define CPIO_RST_OUTMODE 8'h00
`define CPIO_RST_SKIP    8'h00
`define CPIO_RST_ROUTE   8'h00
`define CPIO_RST_INMODE  8'hff
`define CPIO_RST_MATVAL  8'hff
`define CPIO_RST_MATMASK 8'h00

//==============================================================
// Route A fields
`define CPIO_A_CMP1_ASYNC 7
`define CPIO_A_CMP1_SYNC  6
`define CPIO_A_CMP0_ASYNC 5
`define CPIO_A_CMP0_SYNC  4
`define CPIO_A_CLOCK_OUT  3
`define CPIO_A_TWOWIRE    2
`define CPIO_A_SERIAL     1
`define CPIO_A_ASYNC      0
// Route B fields
`define CPIO_B_PULLUP_DIS 7
`define CPIO_B_XBAR_EN    6
`define CPIO_B_TIMER1     5
`define CPIO_B_TIMER0     4
`define CPIO_B_COUNTER    3
`define CPIO_B_CAPT_HI    2
`define CPIO_B_CAPT_LO    0
`define CPIO_CAPT_RSVD    3'h7

//==============================================================
// Peripheral signal indices, in priority order
`define CPIO_SIG_TX    0
`define CPIO_SIG_RX    1
`define CPIO_SIG_SCK   2
`define CPIO_SIG_MISO  3
`define CPIO_SIG_MOSI  4
`define CPIO_SIG_NSS   5
`define CPIO_SIG_SDA   6
`define CPIO_SIG_SCL   7
`define CPIO_SIG_CP0   8
`define CPIO_SIG_CP0A  9
`define CPIO_SIG_CP1   10
`define CPIO_SIG_CP1A  11
`define CPIO_SIG_CLK   12
`define CPIO_SIG_CAPTURE_MODULE_OUT_FIRST  13
`define CPIO_SIG_ECI   19
`define CPIO_SIG_T0    20
`define CPIO_SIG_T1    21
`define CPIO_NUM_SIG   22
// Signals whose peripheral enable may drive a pin (inputs RX, COUNTER_EXT_INPUT, T0, T1 never do; CLK is driven locally)
`define CPIO_SIG_DRIVES 22'h07effd
// Fixed async serial pins, large and small packages
`define CPIO_TX_PIN_LARGE 1
`define CPIO_RX_PIN_LARGE 2
`define CPIO_TX_PIN_SMALL 4
`define CPIO_RX_PIN_SMALL 5

`endif

// *** cpio_io_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
//==============================================================
// Port-level checks of the crossbar port block
module cpio_io_props (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_b,
  // Register bus
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrite,
  input wire logic [7:0] sfrWdata,
  input wire logic       sfrRead,
  input wire logic       sfrRmw,
  input wire logic [7:0] sfrRdata,
  input wire logic       match_irq_enable,
  // Pins
  input wire logic [7:0] port0PinOut,
  input wire logic [7:0] port0PinOe,
  input wire logic [7:0] port0Pullup,
  input wire logic [7:0] port1PinOut,
  input wire logic [7:0] port1PinOe,
  input wire logic [7:0] port1Pullup,
  // Match event
  input wire logic       matchEvent,
  input wire logic       matchIrqReq,
  input wire logic       oscWake
);
  logic       xbarOn;
  logic       pullupDis;
  logic [7:0] inMode;
  logic [7:0] mask;
  logic [7:0] latch0;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Mirrors of the registers that shape the pins, fed by bus writes only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      xbarOn <= 1'b0;
      pullupDis <= 1'b0;
      inMode <= 8'hff;
      mask <= 8'h00;
      latch0 <= 8'hff;
    end else if (sfrWrite) begin
      if (sfrAddr == 8'he2) xbarOn <= sfrWdata[6];
      if (sfrAddr == 8'he2) pullupDis <= sfrWdata[7];
      if (sfrAddr == 8'hf1) inMode <= sfrWdata;
      if (sfrAddr == 8'hf4) mask <= sfrWdata;
      if (sfrAddr == 8'h80) latch0 <= sfrWdata;
    end
  end

  //==============================================================
  // Assertions; outputs trail a register write by one edge
  xbar_off_a: assert property (!xbarOn && !$past(xbarOn) |->
    port0PinOe == 8'h00 && port1PinOe == 8'h00)
    else $error("drivers on with crossbar off");
  irq_req_a: assert property (matchIrqReq == (matchEvent && $past(match_irq_enable)))
    else $error("interrupt request mismatch");
  osc_wake_a: assert property (oscWake == matchEvent)
    else $error("wake differs from event");
  low_pullup_a: assert property ((port0Pullup & port0PinOe & ~port0PinOut) == 8'h00)
    else $error("pullup on a low output");
  analog_pin_a: assert property (inMode == $past(inMode) |->
    ((port0Pullup | port0PinOe) & ~inMode) == 8'h00)
    else $error("analog pin driven or pulled");
  pullup_off_a: assert property (pullupDis && $past(pullupDis) |->
    port0Pullup == 8'h00 && port1Pullup == 8'h00)
    else $error("pullup while disabled");
  rmw_latch_a: assert property (sfrRead && sfrRmw && sfrAddr == 8'h80 |=>
    sfrRdata == $past(latch0))
    else $error("modify read not latch");
  drain_high_a: assert property ((port1PinOe & port1PinOut) == 8'h00)
    else $error("open-drain pin driven high");
  mask_zero_a: assert property (mask == 8'h00 && $past(mask) == 8'h00 &&
    $past(mask, 2) == 8'h00 |-> !matchEvent)
    else $error("event with empty mask");
endmodule : cpio_io_props

bind cpio_crossbar_port_io cpio_io_props u_props (
  .sys_clk(sys_clk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
  .sfrWdata(sfrWdata), .sfrRead(sfrRead), .sfrRmw(sfrRmw), .sfrRdata(sfrRdata),
  .match_irq_enable(match_irq_enable), .port0PinOut(port0PinOut),
  .port0PinOe(port0PinOe), .port0Pullup(port0Pullup), .port1PinOut(port1PinOut),
  .port1PinOe(port1PinOe), .port1Pullup(port1Pullup), .matchEvent(matchEvent),
  .matchIrqReq(matchIrqReq), .oscWake(oscWake)
);
`default_nettype wire

// *** cpio_pkg.sv ***
//==============================================================
// Shared types
package cpio_pkg;
  typedef logic [4:0] cpio_sel_t;  // Peripheral signal index
  typedef logic [7:0] cpio_byte_t;
  typedef logic [21:0] cpio_sigvec_t;
endpackage : cpio_pkg
